// [rtl/mec_top.v]
// master and cache-bank memory error capture
// Function
// R1: bank B nonexistent-memory error latches address; full address uses region bits 12-15.
// R2: any detecting controller captures failing transfer data in its error data register.
// R3: master records its own error region in region register bits 0-3.
// R4: master records involved device port in control status bits 10-12.
// R5: master diagnostic bit 14 set for non-maskable report, clear for ordinary.
// R6: master logs address parity and write-data parity as distinct conditions.
// R7: master write-data parity error gives byte lane in control status bits 0-3.
// R8: bank A refresh parity error latches address; region bits 8-11 complete it.
// R9: normal-access parity address pairs with region bits 8-11 or 20-23, undistinguished.
// R10: bank A write-data parity error gives byte lane in own control status 0-3.
// R11: captured fields hold after an error until firmware reads them; master diag bit 14 here still follows any unit's new event.
`timescale 1ns/1ps
`include "mec_defines.vh"
module mec_top (
  // clock and reset
  input  wire                          clk_i,
  input  wire                          nrst_i,
  input  wire                          ce_i,
  // region select (held by firmware)
  input  wire [`MEC_DW-1:0]            region_select_reg_i,
  // master controller error events
  input  wire                          m_nxm_i,
  input  wire                          m_apar_i,
  input  wire                          m_wpar_i,
  input  wire [`MEC_AW-1:0]            m_addr_i,
  input  wire [`MEC_DW-1:0]            m_data_i,
  input  wire [3:0]                    m_byte_err_i,
  input  wire [3:0]                    m_region_i,
  input  wire                          port_valid_i,
  input  wire [2:0]                    port_id_i,
  input  wire                          use_nmi_i,
  input  wire                          m_ack_i,
  // cache banks: 0,1 are A, 2,3 are B
  input  wire [`MEC_NBANK-1:0]         b_nxm_i,
  input  wire [`MEC_NBANK-1:0]         b_apar_i,
  input  wire [`MEC_NBANK-1:0]         b_wpar_i,
  input  wire [`MEC_NBANK-1:0]         b_refresh_i,
  input  wire [`MEC_NBANK*`MEC_AW-1:0] b_addr_i,
  input  wire [`MEC_NBANK*`MEC_DW-1:0] b_data_i,
  input  wire [`MEC_NBANK*4-1:0]       b_byte_err_i,
  input  wire [`MEC_NBANK-1:0]         b_ack_i,
  // master captured registers
  output wire [`MEC_AW-1:0]            m_error_address_reg_o,
  output wire [`MEC_DW-1:0]            m_error_data_reg_o,
  output wire [`MEC_DW-1:0]            m_error_region_reg_o,
  output wire [`MEC_DW-1:0]            m_control_status_reg_o,
  output wire [`MEC_DW-1:0]            m_diag_status_reg_o,
  output wire [2:0]                    m_kind_o,
  output wire                          m_valid_o,
  // bank captured registers
  output wire [`MEC_NBANK*`MEC_AW-1:0] b_error_address_reg_o,
  output wire [`MEC_NBANK*`MEC_DW-1:0] b_error_data_reg_o,
  output wire [`MEC_NBANK*`MEC_DW-1:0] b_control_status_reg_o,
  output wire [`MEC_NBANK*3-1:0]       b_kind_o,
  output wire [`MEC_NBANK-1:0]         b_refresh_o,
  output wire [`MEC_NBANK-1:0]         b_valid_o,
  // region bits that complete each bank address
  output wire [`MEC_NBANK*4-1:0]       b_mem_region_o,
  output wire [3:0]                    a_reg_region_o,
  // reporting
  output wire                          nmi_o,
  output wire                          controller_irq_line_o
);
  // report path states, one-hot
  localparam [2:0] RPT_IDLE = 3'h1;
  localparam [2:0] RPT_NMI  = 3'h2;
  localparam [2:0] RPT_IRQ  = 3'h4;

  // an event counts only where its unit is not already holding a capture
  wire                  m_ev     = m_nxm_i | m_apar_i | m_wpar_i;
  wire [`MEC_NBANK-1:0] b_ev     = b_nxm_i | b_apar_i | b_wpar_i;
  wire                  m_new    = m_ev & ~m_valid_o;
  wire [`MEC_NBANK-1:0] b_new    = b_ev & ~b_valid_o;
  wire                  any_new  = m_new | (|b_new);
  wire                  any_busy = m_valid_o | (|b_valid_o);
  wire                  any_ack  = m_ack_i | (|b_ack_i);

  // master status words and report state
  reg  [`MEC_DW-1:0]    region_r;
  reg  [`MEC_DW-1:0]    region_nxt;
  reg  [`MEC_DW-1:0]    csr_r;
  reg  [`MEC_DW-1:0]    csr_nxt;
  reg  [`MEC_DW-1:0]    dsr_r;
  reg  [`MEC_DW-1:0]    dsr_nxt;
  reg  [2:0]            rpt_r;
  reg  [2:0]            rpt_nxt;

  // the master has no refresh path, so its refresh flag stays low
  mec_capture u_master (
    .clk_i               (clk_i),
    .nrst_i              (nrst_i),
    .ce_i                (ce_i),
    .nxm_i               (m_nxm_i),
    .apar_i              (m_apar_i),
    .wpar_i              (m_wpar_i),
    .refresh_i           (1'b0),
    .addr_i              (m_addr_i),
    .data_i              (m_data_i),
    .byte_err_i          (m_byte_err_i),
    .ack_i               (m_ack_i),
    .error_address_reg_o (m_error_address_reg_o),
    .error_data_reg_o    (m_error_data_reg_o),
    .byte_lane_o         (),
    .kind_o              (m_kind_o),
    .refresh_o           (),
    .valid_o             (m_valid_o)
  );

  // one capture per cache bank; packed buses carry bank g at g times the width
  genvar g;
  generate
    for (g = 0; g < `MEC_NBANK; g = g + 1) begin : g_bank
      wire [3:0] lane;
      mec_capture u_bank (
        .clk_i               (clk_i),
        .nrst_i              (nrst_i),
        .ce_i                (ce_i),
        .nxm_i               (b_nxm_i[g]),
        .apar_i              (b_apar_i[g]),
        .wpar_i              (b_wpar_i[g]),
        .refresh_i           (b_refresh_i[g]),
        .addr_i              (b_addr_i[g*`MEC_AW +: `MEC_AW]),
        .data_i              (b_data_i[g*`MEC_DW +: `MEC_DW]),
        .byte_err_i          (b_byte_err_i[g*4 +: 4]),
        .ack_i               (b_ack_i[g]),
        .error_address_reg_o (b_error_address_reg_o[g*`MEC_AW +: `MEC_AW]),
        .error_data_reg_o    (b_error_data_reg_o[g*`MEC_DW +: `MEC_DW]),
        .byte_lane_o         (lane),
        .kind_o              (b_kind_o[g*3 +: 3]),
        .refresh_o           (b_refresh_o[g]),
        .valid_o             (b_valid_o[g])
      );
      // bank byte lane in its own status bits 0-3
      assign b_control_status_reg_o[g*`MEC_DW +: `MEC_DW] = {28'h000_0000, lane}; // [R10]
      // A banks use region 8-11, B banks 12-15; refresh and access alike
      if (g < 2) begin : g_a
        assign b_mem_region_o[g*4 +: 4] = region_select_reg_i[`MEC_RSR_A_HI:`MEC_RSR_A_LO]; // [R8] [R9]
      end else begin : g_b
        assign b_mem_region_o[g*4 +: 4] = region_select_reg_i[`MEC_RSR_B_HI:`MEC_RSR_B_LO]; // [R1]
      end
    end
  endgenerate

  // no flag tells memory from register region; firmware must try both
  assign a_reg_region_o = region_select_reg_i[`MEC_RSR_REG_HI:`MEC_RSR_REG_LO]; // [R9]

  // region and byte lane only move with a master capture
  always @* begin
    region_nxt = region_r;
    csr_nxt    = csr_r;
    dsr_nxt    = dsr_r;
    if (m_new) begin
      region_nxt[`MEC_ERR_REGION_HI:`MEC_ERR_REGION_LO] = m_region_i; // [R3]
      csr_nxt[`MEC_CSR_BYTE_HI:`MEC_CSR_BYTE_LO]       = m_wpar_i ? m_byte_err_i : 4'h0; // [R7]
    end

    // port field kept until every pending capture is released
    if (any_new && port_valid_i && !any_busy) begin
      csr_nxt[`MEC_CSR_PORT_HI:`MEC_CSR_PORT_LO] = port_id_i; // [R4] [R11]
    end

    // diag bit follows the newest event of any unit
    if (any_new) begin
      dsr_nxt[`MEC_DSR_NMI_BIT] = use_nmi_i; // [R5]
    end
  end

  // a new event picks the line; any release with no new event drops it
  always @* begin
    rpt_nxt = rpt_r;
    case (rpt_r)
      RPT_IDLE: begin
        if (any_new) begin
          rpt_nxt = use_nmi_i ? RPT_NMI : RPT_IRQ; // [R5]
        end
      end
      RPT_NMI: begin
        if (any_new) begin
          rpt_nxt = use_nmi_i ? RPT_NMI : RPT_IRQ; // [R5]
        end else if (any_ack) begin
          rpt_nxt = RPT_IDLE;
        end
      end
      RPT_IRQ: begin
        if (any_new) begin
          rpt_nxt = use_nmi_i ? RPT_NMI : RPT_IRQ; // [R5]
        end else if (any_ack) begin
          rpt_nxt = RPT_IDLE;
        end
      end
      default: begin
        rpt_nxt = RPT_IDLE;
      end
    endcase
  end

  // clock enable low freezes every status word
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      region_r <= `MEC_RST_WORD;
      csr_r    <= `MEC_RST_WORD;
      dsr_r    <= `MEC_RST_WORD;
      // both report lines start low
      rpt_r    <= RPT_IDLE;
    end else if (ce_i) begin
      region_r <= region_nxt;
      csr_r    <= csr_nxt;
      dsr_r    <= dsr_nxt;
      rpt_r    <= rpt_nxt;
    end
  end

  // status words and report lines leave straight from flip-flops
  assign m_error_region_reg_o   = region_r;
  assign m_control_status_reg_o = csr_r;
  assign m_diag_status_reg_o    = dsr_r;
  assign nmi_o                  = rpt_r[1];
  assign controller_irq_line_o  = rpt_r[2];
endmodule

// [inc/mec_defines.vh]
// constants for the memory error capture block
`ifndef MEC_DEFINES_VH
`define MEC_DEFINES_VH
`define MEC_AW            32
`define MEC_DW            32
`define MEC_ERR_REGION_LO 0
`define MEC_ERR_REGION_HI 3
`define MEC_CSR_BYTE_LO   0
`define MEC_CSR_BYTE_HI   3
`define MEC_CSR_PORT_LO   10
`define MEC_CSR_PORT_HI   12
`define MEC_DSR_NMI_BIT   14
`define MEC_RSR_A_LO      8
`define MEC_RSR_A_HI      11
`define MEC_RSR_B_LO      12
`define MEC_RSR_B_HI      15
`define MEC_RSR_REG_LO    20
`define MEC_RSR_REG_HI    23
`define MEC_NBANK         4
`define MEC_RST_WORD      32'h0000_0000
`define MEC_RSR_RST       32'h0000_0000
`endif

// [rtl/mec_capture.v]
// per-controller capture of error address, data, byte lane and kind
`timescale 1ns/1ps
`include "mec_defines.vh"
module mec_capture (
  // clock and reset
  input  wire                    clk_i,
  input  wire                    nrst_i,
  input  wire                    ce_i,
  // error event
  input  wire                    nxm_i,
  input  wire                    apar_i,
  input  wire                    wpar_i,
  input  wire                    refresh_i,
  input  wire [`MEC_AW-1:0]      addr_i,
  input  wire [`MEC_DW-1:0]      data_i,
  input  wire [3:0]              byte_err_i,
  // firmware read release
  input  wire                    ack_i,
  // captured values
  output reg  [`MEC_AW-1:0]      error_address_reg_o,
  output reg  [`MEC_DW-1:0]      error_data_reg_o,
  output reg  [3:0]              byte_lane_o,
  output reg  [2:0]              kind_o,
  output reg                     refresh_o,
  output reg                     valid_o
);
  wire ev = nxm_i | apar_i | wpar_i;
  always @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      error_address_reg_o <= `MEC_RST_WORD;
      error_data_reg_o    <= `MEC_RST_WORD;
      byte_lane_o         <= 4'h0;
      kind_o              <= 3'h0;
      refresh_o           <= 1'b0;
      valid_o             <= 1'b0;
    end else if (ce_i) begin
      // first error wins; later ones are ignored until firmware releases
      if (ev && !valid_o) begin // [R11]
        error_address_reg_o <= addr_i; // [R1] [R8]
        error_data_reg_o    <= data_i; // [R2]
        kind_o              <= {wpar_i, apar_i, nxm_i}; // [R6]
        byte_lane_o         <= wpar_i ? byte_err_i : 4'h0; // [R7] [R10]
        refresh_o           <= refresh_i;
        valid_o             <= 1'b1;
      end else if (ack_i) begin
        valid_o <= 1'b0;
      end
    end
  end
endmodule

// [tb/mec_fw.sv]
// firmware model that reads captured units and then releases them
`timescale 1ns/1ps
module mec_fw #(
  parameter N   = 5,
  parameter DLY = 2
) (
  input  wire         clk_i,
  input  wire         nrst_i,
  input  wire         hold_i,
  input  wire [N-1:0] valid_i,
  output reg  [N-1:0] ack_o
);
  integer cnt;
  // one release pulse for all pending units; hold_i models a slow reader
  always @(negedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_o <= {N{1'b0}};
      cnt   <= 0;
    end else if (ack_o != 0 || hold_i || valid_i == 0) begin
      ack_o <= {N{1'b0}};
      cnt   <= 0;
    end else if (cnt == DLY) begin
      ack_o <= valid_i;
    end else begin
      cnt <= cnt + 1;
    end
  end
endmodule

// [tb/mec_chk.sv]
// assertions on the error capture top ports
`timescale 1ns/1ps
module mec_chk (
  input wire         clk_i, nrst_i, ce_i, m_nxm_i, m_apar_i, m_wpar_i, port_valid_i, use_nmi_i, m_ack_i,
  input wire         m_valid_o, nmi_o,
  input wire [31:0]  region_select_reg_i, m_addr_i, m_error_address_reg_o, m_error_region_reg_o,
  input wire [31:0]  m_control_status_reg_o, m_diag_status_reg_o,
  input wire [3:0]   m_byte_err_i, m_region_i, b_nxm_i, b_valid_o, a_reg_region_o,
  input wire [2:0]   port_id_i, m_kind_o,
  input wire [15:0]  b_mem_region_o,
  input wire [127:0] b_addr_i, b_error_address_reg_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  wire m_ev = ce_i && !m_valid_o && (m_nxm_i || m_apar_i || m_wpar_i);
  property p_kind; m_ev |=> m_valid_o && m_kind_o == $past({m_wpar_i, m_apar_i, m_nxm_i}); endproperty
  a_kind: assert property (p_kind) else $error("kind wrong");
  property p_byte; m_ev |=> m_control_status_reg_o[3:0] == ($past(m_wpar_i) ? $past(m_byte_err_i) : 4'h0); endproperty
  a_byte: assert property (p_byte) else $error("byte lane wrong");
  property p_cap; m_ev |=> m_error_address_reg_o == $past(m_addr_i)
    && m_error_region_reg_o[3:0] == $past(m_region_i); endproperty
  a_cap: assert property (p_cap) else $error("capture wrong");
  property p_port; m_ev && port_valid_i && b_valid_o == 4'h0
    |=> m_control_status_reg_o[12:10] == $past(port_id_i); endproperty
  a_port: assert property (p_port) else $error("port wrong");
  property p_nmi; m_ev |=> m_diag_status_reg_o[14] == $past(use_nmi_i) && nmi_o == $past(use_nmi_i); endproperty
  a_nmi: assert property (p_nmi) else $error("report path wrong");
  property p_hold; m_valid_o && !m_ack_i && ce_i |=> m_valid_o && $stable(m_error_address_reg_o); endproperty
  a_hold: assert property (p_hold) else $error("capture not held");
  property p_bank_b; ce_i && b_nxm_i[2] && !b_valid_o[2] |=> b_error_address_reg_o[95:64] == $past(b_addr_i[95:64]);
  endproperty
  a_bank_b: assert property (p_bank_b) else $error("bank address wrong");
  property p_regs; b_mem_region_o == {{2{region_select_reg_i[15:12]}}, {2{region_select_reg_i[11:8]}}}
    && a_reg_region_o == region_select_reg_i[23:20]; endproperty
  a_regs: assert property (p_regs) else $error("region bits wrong");
  c_nmi: cover property (m_ev && use_nmi_i);
  c_irq: cover property (m_ev && !use_nmi_i);
  c_bank_b: cover property (b_nxm_i[2] && ce_i);
endmodule
bind mec_top mec_chk u_chk (.*);

// [tb/testbench.sv]
// self-checking bench for the error capture top
`timescale 1ns/1ps
module testbench;
  reg          clk_i = 0, nrst_i = 0, ce_i = 1, hold = 1, m_nxm_i = 0, m_apar_i = 0, m_wpar_i = 0;
  reg          port_valid_i = 1, use_nmi_i = 0;
  reg  [31:0]  region_select_reg_i = 32'h00a5_c900, m_addr_i = 0, m_data_i = 0;
  reg  [3:0]   m_byte_err_i = 4'h4, m_region_i = 4'h6, b_nxm_i = 0, b_apar_i = 0, b_wpar_i = 0, b_refresh_i = 0;
  reg  [2:0]   port_id_i = 3'h5;
  reg  [127:0] b_addr_i = 0, b_data_i = 0;
  reg  [15:0]  b_byte_err_i = 0;
  wire [31:0]  m_error_address_reg_o, m_error_data_reg_o, m_error_region_reg_o, m_control_status_reg_o;
  wire [31:0]  m_diag_status_reg_o;
  wire [127:0] b_error_address_reg_o, b_error_data_reg_o, b_control_status_reg_o;
  wire [15:0]  b_mem_region_o;
  wire [11:0]  b_kind_o;
  wire [3:0]   b_refresh_o, b_valid_o, a_reg_region_o, b_ack_i;
  wire [2:0]   m_kind_o;
  wire         m_valid_o, nmi_o, controller_irq_line_o, m_ack_i;
  integer      miscompares = 0, comparisons = 0, i, k;
  mec_top u_dut (.*);
  mec_fw u_fw (.clk_i(clk_i), .nrst_i(nrst_i), .hold_i(hold),
    .valid_i({b_valid_o, m_valid_o}), .ack_o({b_ack_i, m_ack_i}));
  task chk(input string n, input [31:0] e, input [31:0] g);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[ERR] %s exp %h got %h", n, e, g);
      end
    end
  endtask
  task summarize;
    begin
      if (miscompares == 0 && comparisons > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // hold goes by NBA: the reader still sees it high on this falling edge and low from the next one
  task drain;
    begin
      hold <= 0;
      for (i = 0; i < 20 && {m_valid_o, b_valid_o} !== 5'h00; i = i + 1) @(negedge clk_i);
      if ({m_valid_o, b_valid_o} !== 5'h00) begin
        chk("release", 5'h00, {m_valid_o, b_valid_o});
        summarize;
      end else begin
        hold <= 1;
      end
    end
  endtask
  task mev(input [2:0] kd, input nmi, input [31:0] a);
    begin
      @(negedge clk_i);
      {m_wpar_i, m_apar_i, m_nxm_i} = kd;
      use_nmi_i = nmi;
      m_addr_i = a;
      m_data_i = ~a;
      @(negedge clk_i);
      {m_wpar_i, m_apar_i, m_nxm_i} = 3'h0;
    end
  endtask
  task t_master_wpar;
    begin
      mev(3'h4, 1, 32'h1234_5678);
      chk("ear", 32'h1234_5678, m_error_address_reg_o);
      chk("edr", 32'hedcb_a987, m_error_data_reg_o);
      chk("region", 4'h6, m_error_region_reg_o[3:0]);
      chk("port", 3'h5, m_control_status_reg_o[12:10]);
      chk("byte", 4'h4, m_control_status_reg_o[3:0]);
      chk("report", 6'h32, {m_diag_status_reg_o[14], m_kind_o, nmi_o, controller_irq_line_o});
      mev(3'h2, 0, 32'h0bad_0bad);
      chk("held", 32'h1234_5678, m_error_address_reg_o);
      chk("held kind", 3'h4, m_kind_o);
      drain;
      chk("after", 32'hedcb_a987, m_error_data_reg_o);
      chk("lines", 2'h0, {nmi_o, controller_irq_line_o});
    end
  endtask
  task t_master_kinds;
    begin
      port_valid_i = 0;
      m_region_i = 4'h3;
      for (k = 1; k <= 2; k = k + 1) begin
        mev(k[2:0], 0, 32'h0000_a000 + k);
        chk("kind", {k[2:0], 8'h03, 3'h1}, {m_kind_o, m_control_status_reg_o[3:0], m_error_region_reg_o[3:0],
          m_diag_status_reg_o[14], nmi_o, controller_irq_line_o});
        chk("port kept", 3'h5, m_control_status_reg_o[12:10]);
        drain;
      end
    end
  endtask
  task t_freeze;
    begin
      @(negedge clk_i);
      ce_i = 0;
      m_nxm_i = 1;
      m_addr_i = 32'h0000_0f0f;
      @(negedge clk_i);
      chk("frozen", 3'h0, {m_valid_o, nmi_o, controller_irq_line_o});
      chk("frozen ear", 32'h0000_a002, m_error_address_reg_o);
      m_nxm_i = 0;
      ce_i = 1;
    end
  endtask
  task t_bank_b;
    begin
      @(negedge clk_i);
      b_nxm_i = 4'h4;
      b_addr_i[95:64] = 32'h00b0_0040;
      b_data_i[95:64] = 32'h5a5a_0002;
      use_nmi_i = 1;
      @(negedge clk_i);
      b_nxm_i = 4'h0;
      chk("b_ear", 32'h00b0_0040, b_error_address_reg_o[95:64]);
      chk("b_edr", 32'h5a5a_0002, b_error_data_reg_o[95:64]);
      chk("b_info", 9'h187, {b_mem_region_o[11:8], b_kind_o[8:6], b_valid_o[2], m_diag_status_reg_o[14]});
      chk("b_lines", 2'h2, {nmi_o, controller_irq_line_o});
      drain;
    end
  endtask
  task t_bank_a;
    begin
      @(negedge clk_i);
      {b_wpar_i, b_refresh_i, b_apar_i} = 12'h112;
      b_addr_i[31:0] = 32'h0000_a0a0;
      b_byte_err_i[3:0] = 4'h8;
      use_nmi_i = 0;
      @(negedge clk_i);
      {b_wpar_i, b_refresh_i, b_apar_i} = 12'h000;
      chk("a_ear", 32'h0000_a0a0, b_error_address_reg_o[31:0]);
      chk("a_csr", 13'h119a, {b_control_status_reg_o[3:0], b_refresh_o[0], b_mem_region_o[3:0], a_reg_region_o});
      chk("a_report", 3'h1, {m_diag_status_reg_o[14], nmi_o, controller_irq_line_o});
      drain;
    end
  endtask
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  initial begin
    repeat (20) @(negedge clk_i);
    nrst_i = 1;
    t_master_wpar;
    t_master_kinds;
    t_freeze;
    t_bank_b;
    t_bank_a;
    summarize;
  end
endmodule
